// >>> core/lvm_pkg.sv
package lvm_pkg;
    // ---------------------------------------------------------------
    // Register addresses (5-bit command field)
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_ZC_TIMEOUT = 5'h0E;
    localparam logic [4:0] ADDR_GAIN       = 5'h10;
    localparam logic [4:0] ADDR_CUR_OFS    = 5'h11;
    localparam logic [4:0] ADDR_VOLT_OFS   = 5'h12;
    localparam logic [4:0] ADDR_SAG_LVL    = 5'h13;
    localparam logic [4:0] ADDR_SAG_CYC    = 5'h14;
    localparam logic [4:0] ADDR_MODE       = 5'h15;
    localparam logic [4:0] ADDR_IRQ_EN     = 5'h16;
    localparam logic [4:0] ADDR_STATUS     = 5'h17;
    // Command byte: bit 7 write, bits 4:0 address
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_ADDR_W    = 5;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GAIN_CUR_LSB   = 0;
    localparam int GAIN_RANGE_LSB = 3;
    localparam int GAIN_VOLT_LSB  = 5;
    localparam int MODE_HPF_BIT   = 0;
    localparam int MODE_SAG_PIN_DISABLE_BIT = 1;
    localparam int MODE_TEMP_BIT  = 2;
    localparam int IRQ_SAG_BIT    = 0;
    localparam int STAT_SAG_BIT   = 0;
    localparam int STAT_ACT_BIT   = 1;
    localparam int OFS_W          = 6;
    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [15:0] TIMEOUT_RST  = 16'hFFFF;
    localparam logic [7:0]  GAIN_RST     = 8'h00;
    localparam logic [7:0]  MODE_RST     = 8'h01;
    localparam logic [7:0]  SAG_LVL_RST  = 8'h00;
    localparam logic [7:0]  SAG_CYC_RST  = 8'h00;
    localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
    localparam int          TICK_CLOCKS  = 64;
    localparam logic [4:0]  LEN_BYTE     = 5'h08;
    localparam logic [4:0]  LEN_WORD     = 5'h10;
endpackage

// >>> core/lvm_tmr_if.sv
`timescale 1ns/1ps
interface lvm_tmr_if;
    logic        zc;
    logic        load;
    logic [15:0] load_val;
    logic        expired;
    logic [15:0] prog_val;
    logic [15:0] count;

    modport ctl (output zc, output load, output load_val,
                 input expired, input prog_val, input count);
    modport tmr (input zc, input load, input load_val,
                 output expired, output prog_val, output count);
endinterface

// >>> core/lvm_zc_timer.sv
`timescale 1ns/1ps
module lvm_zc_timer #(
    parameter int TICK = lvm_pkg::TICK_CLOCKS
) (
    input  wire logic mclk,
    input  wire logic rst_i,
    lvm_tmr_if.tmr    tif
);
    initial begin
        if (TICK < 2 || TICK > 64) $error("lvm_zc_timer: TICK out of range");
    end

    typedef struct packed {
        logic [5:0]  pre;
        logic [15:0] prog;
        logic [15:0] cnt;
        logic        exp;
    } lvm_tmr_st_t;

    localparam logic [5:0] PRE_LAST = 6'(TICK - 1);

    lvm_tmr_st_t s_r;
    lvm_tmr_st_t s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.exp = 1'b0;
        if (s_r.pre == PRE_LAST) begin
            s_nxt.pre = 6'h00;
        end else begin
            s_nxt.pre = s_r.pre + 6'h01;
        end
        if (tif.load) begin
            s_nxt.prog = tif.load_val;
            s_nxt.cnt  = tif.load_val;
        end else if (tif.zc) begin
            s_nxt.cnt = s_r.prog;
        end else if (s_r.pre == PRE_LAST && s_r.cnt != 16'h0000) begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
            s_nxt.exp = (s_r.cnt == 16'h0001);
        end
        if (rst_i) begin
            s_nxt = '{pre: 6'h00, prog: lvm_pkg::TIMEOUT_RST,
                      cnt: lvm_pkg::TIMEOUT_RST, exp: 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    assign tif.expired  = s_r.exp;
    assign tif.prog_val = s_r.prog;
    assign tif.count    = s_r.cnt;
endmodule // lvm_zc_timer

// >>> core/lvm_line_monitor.sv
`timescale 1ns/1ps
module lvm_line_monitor #(
    parameter int SAMPLE_W = 20
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                supply_low,
    // Serial port
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                din,
    output logic                     dout,
    output logic                     dout_oe,
    // Filtered voltage channel
    input  wire logic [SAMPLE_W-1:0] volt_lowpass_sample,
    input  wire logic                volt_lowpass_valid,
    // Pins
    output logic                     zero_cross_out,
    output logic                     sag_n_o,
    output logic                     sag_n_oe,
    output logic                     irq_n_o,
    output logic                     irq_n_oe,
    // Front-end settings
    output logic [2:0]               current_amp_gain,
    output logic [1:0]               current_range,
    output logic [2:0]               voltage_amp_gain,
    output logic [5:0]               current_offset_trim,
    output logic [5:0]               voltage_offset_trim,
    output logic                     current_highpass_en,
    output logic                     temp_start
);
    initial begin
        if (SAMPLE_W < 10) $error("lvm_line_monitor: SAMPLE_W too small");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SER_CMD  = 2'b00,
        SER_WR   = 2'b01,
        SER_RD   = 2'b11,
        SER_DONE = 2'b10
    } lvm_ser_st_t;

    typedef struct packed {
        lvm_ser_st_t st;
        logic        sclk_q;
        logic [4:0]  bits;
        logic [4:0]  len;
        logic [7:0]  cmd;
        logic [15:0] sh;
        logic [15:0] tx;
        logic        dout;
        logic [7:0]  gain;
        logic [5:0]  cur_ofs;
        logic [5:0]  volt_ofs;
        logic [7:0]  sag_lvl;
        logic [7:0]  sag_cyc;
        logic [7:0]  mode;
        logic [7:0]  irq_en;
        logic        sag_flag;
        logic        sag_act;
        logic        zx;
        logic        above;
        logic [7:0]  hcnt;
        logic        tmr_load;
        logic [15:0] tmr_val;
        logic        zc;
        logic        temp_go;
    } lvm_st_t;

    localparam lvm_st_t ST_RST = '{
        st: SER_CMD, sclk_q: 1'b0, bits: 5'h00, len: 5'h00, cmd: 8'h00,
        sh: 16'h0000, tx: 16'h0000, dout: 1'b0,
        gain: lvm_pkg::GAIN_RST, cur_ofs: 6'h00, volt_ofs: 6'h00,
        sag_lvl: lvm_pkg::SAG_LVL_RST, sag_cyc: lvm_pkg::SAG_CYC_RST,
        mode: lvm_pkg::MODE_RST, irq_en: lvm_pkg::IRQ_EN_RST,
        sag_flag: 1'b0, sag_act: 1'b0, zx: 1'b0, above: 1'b0, hcnt: 8'h00,
        tmr_load: 1'b0, tmr_val: 16'h0000, zc: 1'b0, temp_go: 1'b0};

    lvm_st_t s_r;
    lvm_st_t s_nxt;
    logic    rst_i;

    lvm_tmr_if tif ();

    // Supply monitor folds into the one internal reset
    assign rst_i = ~rst_n | supply_low;

    lvm_zc_timer #(
        .TICK (lvm_pkg::TICK_CLOCKS)
    ) u_timer (
        .mclk  (mclk),
        .rst_i (rst_i),
        .tif   (tif)
    );

    assign tif.zc       = s_r.zc;
    assign tif.load     = s_r.tmr_load;
    assign tif.load_val = s_r.tmr_val;

    // ---------------------------------------------------------------
    // Register read mux, byte values left aligned for shifting out
    // ---------------------------------------------------------------
    function automatic logic [15:0] rd_val(input lvm_st_t s, input logic [4:0] a,
                                           input logic [15:0] tout);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            lvm_pkg::ADDR_ZC_TIMEOUT: v = tout;
            lvm_pkg::ADDR_GAIN:       v = {s.gain, 8'h00};
            lvm_pkg::ADDR_CUR_OFS:    v = {2'b00, s.cur_ofs, 8'h00};
            lvm_pkg::ADDR_VOLT_OFS:   v = {2'b00, s.volt_ofs, 8'h00};
            lvm_pkg::ADDR_SAG_LVL:    v = {s.sag_lvl, 8'h00};
            lvm_pkg::ADDR_SAG_CYC:    v = {s.sag_cyc, 8'h00};
            lvm_pkg::ADDR_MODE:       v = {s.mode, 8'h00};
            lvm_pkg::ADDR_IRQ_EN:     v = {s.irq_en, 8'h00};
            lvm_pkg::ADDR_STATUS:     v = {6'h00, s.sag_act, s.sag_flag, 8'h00};
            default:                  v = 16'h0000;
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic [SAMPLE_W-1:0] mag;
    logic [7:0]          mag_byte;
    logic                fall;
    logic                rise;
    logic                clr_flag;
    logic                sag_evt;
    logic                new_zx;
    logic [15:0]         wdata;
    logic [4:0]          addr;
    logic [7:0]          hinc;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tmr_load = 1'b0;
        s_nxt.zc   = 1'b0;
        s_nxt.temp_go = 1'b0;
        clr_flag   = 1'b0;
        sag_evt    = 1'b0;
        fall       = s_r.sclk_q & ~sclk;
        rise       = ~s_r.sclk_q & sclk;
        wdata      = {s_r.sh[14:0], din};
        addr       = s_r.cmd[lvm_pkg::CMD_ADDR_W-1:0];
        s_nxt.sclk_q = sclk;

        // Serial port: bits enter on the falling edge, leave on the rising edge
        if (cs_n) begin
            s_nxt.st   = SER_CMD;
            s_nxt.bits = 5'h00;
        end else if (fall) begin
            s_nxt.sh   = wdata;
            s_nxt.bits = s_r.bits + 5'h01;
            case (s_r.st)
                SER_CMD: begin
                    if (s_r.bits == 5'h07) begin
                        s_nxt.cmd  = wdata[7:0];
                        s_nxt.bits = 5'h00;
                        s_nxt.len  = (wdata[4:0] == lvm_pkg::ADDR_ZC_TIMEOUT) ?
                                     lvm_pkg::LEN_WORD : lvm_pkg::LEN_BYTE;
                        if (wdata[lvm_pkg::CMD_WRITE_BIT]) begin
                            s_nxt.st = SER_WR;
                        end else begin
                            s_nxt.st = SER_RD;
                            s_nxt.tx = rd_val(s_r, wdata[4:0], tif.prog_val);
                            clr_flag = (wdata[4:0] == lvm_pkg::ADDR_STATUS);
                        end
                    end
                end
                SER_WR: begin
                    if (s_r.bits + 5'h01 == s_r.len) begin
                        s_nxt.st = SER_DONE;
                        case (addr)
                            lvm_pkg::ADDR_ZC_TIMEOUT: begin
                                s_nxt.tmr_load = 1'b1;
                                s_nxt.tmr_val  = wdata;
                            end
                            lvm_pkg::ADDR_GAIN:     s_nxt.gain     = wdata[7:0];
                            lvm_pkg::ADDR_CUR_OFS:  s_nxt.cur_ofs  = wdata[5:0];
                            lvm_pkg::ADDR_VOLT_OFS: s_nxt.volt_ofs = wdata[5:0];
                            lvm_pkg::ADDR_SAG_LVL:  s_nxt.sag_lvl  = wdata[7:0];
                            lvm_pkg::ADDR_SAG_CYC:  s_nxt.sag_cyc  = wdata[7:0];
                            lvm_pkg::ADDR_MODE:     s_nxt.mode     = wdata[7:0];
                            lvm_pkg::ADDR_IRQ_EN:   s_nxt.irq_en   = wdata[7:0];
                            default: s_nxt.st = SER_DONE;
                        endcase
                    end
                end
                SER_RD: begin
                    if (s_r.bits + 5'h01 == s_r.len) begin
                        s_nxt.st = SER_DONE;
                    end
                end
                default: s_nxt.st = SER_DONE;
            endcase
        end else if (rise && s_r.st == SER_RD) begin
            s_nxt.dout = s_r.tx[15];
            s_nxt.tx   = {s_r.tx[14:0], 1'b0};
        end

        // -----------------------------------------------------------
        // Zero crossing and level sag
        // -----------------------------------------------------------
        mag      = volt_lowpass_sample[SAMPLE_W-1] ?
                   (~volt_lowpass_sample + 1'b1) : volt_lowpass_sample;
        mag_byte = mag[SAMPLE_W-2 -: 8];
        new_zx   = ~volt_lowpass_sample[SAMPLE_W-1];
        hinc     = (s_r.hcnt == 8'hFF) ? s_r.hcnt : s_r.hcnt + 8'h01;
        if (volt_lowpass_valid) begin
            s_nxt.zx = new_zx;
            if (mag_byte > s_r.sag_lvl) begin
                s_nxt.above   = 1'b1;
                s_nxt.hcnt    = 8'h00;
                s_nxt.sag_act = 1'b0;
            end
            if (new_zx != s_r.zx) begin
                s_nxt.zc    = 1'b1;
                s_nxt.above = 1'b0;
                s_nxt.temp_go = s_r.mode[lvm_pkg::MODE_TEMP_BIT];
                // A half cycle counts only when no sample in it rose above
                if (!s_r.above && !(mag_byte > s_r.sag_lvl)) begin
                    s_nxt.hcnt = hinc;
                    if (s_r.sag_cyc != 8'h00 && hinc == s_r.sag_cyc) begin
                        sag_evt = 1'b1;
                    end
                end
            end
        end
        if (tif.expired) begin
            sag_evt = 1'b1;
        end
        if (sag_evt) begin
            s_nxt.sag_act = 1'b1;
        end
        // Temperature request self-clears once launched
        if (s_nxt.temp_go) begin
            s_nxt.mode[lvm_pkg::MODE_TEMP_BIT] = 1'b0;
        end
        // Set wins over the read-with-clear
        if (clr_flag) begin
            s_nxt.sag_flag = 1'b0;
        end
        if (sag_evt) begin
            s_nxt.sag_flag = 1'b1;
        end
        if (rst_i) begin
            s_nxt = ST_RST;
        end
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign dout           = s_r.dout;
    assign dout_oe        = ~cs_n & (s_r.st == SER_RD);
    assign zero_cross_out = s_r.zx;
    assign sag_n_o        = 1'b0;
    // Reset drives the pin straight from the inputs so a supervisor sees it at once
    assign sag_n_oe       = rst_i |
                            (s_r.sag_act & ~s_r.mode[lvm_pkg::MODE_SAG_PIN_DISABLE_BIT]);
    assign irq_n_o        = 1'b0;
    assign irq_n_oe       = s_r.sag_flag & s_r.irq_en[lvm_pkg::IRQ_SAG_BIT];
    assign current_amp_gain    = s_r.gain[lvm_pkg::GAIN_CUR_LSB +: 3];
    assign current_range       = s_r.gain[lvm_pkg::GAIN_RANGE_LSB +: 2];
    assign voltage_amp_gain    = s_r.gain[lvm_pkg::GAIN_VOLT_LSB +: 3];
    assign current_offset_trim = s_r.cur_ofs;
    assign voltage_offset_trim = s_r.volt_ofs;
    // Host must clear this before trimming the current offset
    assign current_highpass_en = s_r.mode[lvm_pkg::MODE_HPF_BIT];
    assign temp_start          = s_r.temp_go;
endmodule // lvm_line_monitor

// >>> sim/lvm_props.sv
`timescale 1ns/1ps
module lvm_props #(
    parameter int SAMPLE_W = 20
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                supply_low,
    input wire logic                cs_n,
    input wire logic [SAMPLE_W-1:0] volt_lowpass_sample,
    input wire logic                volt_lowpass_valid,
    input wire logic                zero_cross_out,
    input wire logic                sag_n_oe,
    input wire logic                irq_n_oe,
    input wire logic [2:0]          current_amp_gain,
    input wire logic [1:0]          current_range,
    input wire logic [2:0]          voltage_amp_gain,
    input wire logic [5:0]          current_offset_trim,
    input wire logic [5:0]          voltage_offset_trim,
    input wire logic                current_highpass_en,
    input wire logic                temp_start
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n || supply_low);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Three quiet cycles so a write landing just after the last bit is not flagged
    sequence bus_quiet_s; cs_n [*3]; endsequence
    sequence reset_exit_s; $rose(rst_n) && !supply_low; endsequence
    sequence new_sample_s; volt_lowpass_valid; endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sag_reset_low_a: assert property (disable iff (1'b0) !rst_n |-> sag_n_oe)
        else $error("sag pin released during reset");
    supply_reset_a: assert property (disable iff (1'b0) supply_low |-> sag_n_oe)
        else $error("sag pin released while supply low");
    irq_reset_a: assert property (disable iff (1'b0) !rst_n |=> !irq_n_oe)
        else $error("irq pin active after reset edge");
    sag_exit_clear_a: assert property (reset_exit_s |-> !sag_n_oe)
        else $error("sag pin active right after reset");
    zx_track_a: assert property (new_sample_s |=>
        zero_cross_out == !$past(volt_lowpass_sample[SAMPLE_W-1]))
        else $error("zero cross output does not follow sample sign");
    zx_hold_a: assert property (!volt_lowpass_valid |=> $stable(zero_cross_out))
        else $error("zero cross output moved without a sample");
    // A reset in the previous cycle legitimately reloads every setting
    settings_hold_a: assert property (bus_quiet_s ##0
        ($past(rst_n) && !$past(supply_low)) |-> $stable({current_amp_gain,
        current_range, voltage_amp_gain, current_offset_trim, voltage_offset_trim,
        current_highpass_en})) else $error("front-end setting changed with port idle");
    temp_pulse_a: assert property (temp_start |=> !temp_start)
        else $error("temperature start longer than one cycle");
    temp_cause_a: assert property (temp_start |-> $past(volt_lowpass_valid) ||
        $past(volt_lowpass_valid, 2) || $past(volt_lowpass_valid, 3))
        else $error("temperature start without a sample");
endmodule // lvm_props

bind lvm_line_monitor lvm_props #(.SAMPLE_W(SAMPLE_W)) props (
    .mclk(mclk), .rst_n(rst_n), .supply_low(supply_low), .cs_n(cs_n),
    .volt_lowpass_sample(volt_lowpass_sample), .volt_lowpass_valid(volt_lowpass_valid),
    .zero_cross_out(zero_cross_out), .sag_n_oe(sag_n_oe), .irq_n_oe(irq_n_oe),
    .current_amp_gain(current_amp_gain), .current_range(current_range),
    .voltage_amp_gain(voltage_amp_gain), .current_offset_trim(current_offset_trim),
    .voltage_offset_trim(voltage_offset_trim), .current_highpass_en(current_highpass_en),
    .temp_start(temp_start));

// >>> sim/lvm_host_bfm.sv
`timescale 1ns/1ps
module lvm_host_bfm (
    input  wire logic mclk,
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    // Four mclk per serial level leaves room for the port's sclk edge detector
    localparam int HALF = 4;
    logic line_r;

    initial begin
        cs_n   = 1'b1;
        sclk   = 1'b0;
        din    = 1'b0;
        line_r = 1'b0;
    end
    // ----------------------------------------
    // Serial transfer, MSB first
    // ----------------------------------------
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rdat);
        logic [23:0] sh;
        int          n;
        n = (cmd[4:0] == lvm_pkg::ADDR_ZC_TIMEOUT) ? 24 : 16;
        sh = (n == 24) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
        rdat = 16'h0000;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (HALF) @(negedge mclk);
            sclk = 1'b1;
            din  = sh[23-i];
            repeat (HALF) @(negedge mclk);
            // A released line reads back inverted so a stale bit never passes
            line_r = dout_oe ? dout : ~line_r;
            if (i >= 8) rdat = {rdat[14:0], line_r};
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge mclk);
        cs_n = 1'b1;
    endtask

    task automatic trim_current(input logic [5:0] val);
        logic [15:0] rd;
        xfer({3'b100, lvm_pkg::ADDR_MODE}, 16'h0000, rd);
        xfer({3'b100, lvm_pkg::ADDR_CUR_OFS}, {10'h000, val}, rd);
    endtask
endmodule // lvm_host_bfm

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int SW = 20;
    logic          mclk, rst_n, supply_low, cs_n, sclk, din, dout, dout_oe;
    logic          volt_lowpass_valid, zero_cross_out, sag_n_o, sag_n_oe, irq_n_o, irq_n_oe;
    logic          current_highpass_en, temp_start;
    logic [SW-1:0] volt_lowpass_sample, v;
    logic [2:0]    current_amp_gain, voltage_amp_gain;
    logic [1:0]    current_range;
    logic [5:0]    current_offset_trim, voltage_offset_trim;
    logic [15:0]   rd, tw;
    logic [7:0]    g;
    int            n_mismatch, cmp_count, seed, pulses;

    lvm_host_bfm host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
                       .dout_oe(dout_oe));
    lvm_line_monitor #(.SAMPLE_W(SW)) dut (
        .mclk(mclk), .rst_n(rst_n), .supply_low(supply_low), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .dout_oe(dout_oe), .volt_lowpass_sample(volt_lowpass_sample),
        .volt_lowpass_valid(volt_lowpass_valid), .zero_cross_out(zero_cross_out),
        .sag_n_o(sag_n_o), .sag_n_oe(sag_n_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
        .current_amp_gain(current_amp_gain), .current_range(current_range),
        .voltage_amp_gain(voltage_amp_gain), .current_offset_trim(current_offset_trim),
        .voltage_offset_trim(voltage_offset_trim), .current_highpass_en(current_highpass_en),
        .temp_start(temp_start));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic s);
        chk_word(nm, {15'h0000, e}, {15'h0000, s});
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host.xfer({3'b100, a}, d, rd);
    endtask
    task automatic rdr(input logic [4:0] a, output logic [15:0] d);
        host.xfer({3'b000, a}, 16'h0000, d);
    endtask
    task automatic smp(input logic [SW-1:0] s);
        @(negedge mclk);
        volt_lowpass_sample = s;
        volt_lowpass_valid  = 1'b1;
        @(negedge mclk);
        volt_lowpass_valid = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    // Sample whose magnitude, shifted left once, has b as its top byte
    function automatic logic [SW-1:0] at_level(input logic [7:0] b, input logic neg);
        logic [SW-1:0] m;
        m = {1'b0, b, 11'h000};
        return neg ? -m : m;
    endfunction

    always @(posedge mclk) if (temp_start === 1'b1) pulses++;
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h06bb;
        rst_n = 1'b0;
        supply_low = 1'b0;
        volt_lowpass_valid = 1'b0;
        volt_lowpass_sample = '0;
        repeat (4) @(negedge mclk);
        chk_bit("sag_in_reset", 1'b1, sag_n_oe);
        chk_bit("open_drain", 1'b0, sag_n_o | irq_n_o);
        chk_bit("hpf_rst", 1'b1, current_highpass_en);
        rst_n = 1'b1;
        rdr(lvm_pkg::ADDR_ZC_TIMEOUT, rd);
        chk_word("timeout_rst", 16'hFFFF, rd);
        for (int a = 16; a < 24; a++) begin
            rdr((a == 23) ? 5'h1F : 5'(a), rd);
            chk_word("reg_rst", (a == 21) ? 16'h0001 : 16'h0000, rd);
        end
        for (int i = 0; i < 6; i++) begin
            g = 8'($random(seed));
            wr(lvm_pkg::ADDR_GAIN, {8'h00, g});
            chk_word("cur_gain", {13'h0000, g[2:0]}, {13'h0000, current_amp_gain});
            chk_word("volt_gain", {13'h0000, g[7:5]}, {13'h0000, voltage_amp_gain});
            chk_word("range", {14'h0000, g[4:3]}, {14'h0000, current_range});
            host.trim_current(g[5:0]);
            chk_bit("hpf_off", 1'b0, current_highpass_en);
            chk_word("cur_trim", {10'h000, g[5:0]}, {10'h000, current_offset_trim});
            wr(lvm_pkg::ADDR_VOLT_OFS, {8'h00, ~g});
            rdr(lvm_pkg::ADDR_VOLT_OFS, rd);
            chk_word("volt_trim", {10'h000, ~g[5:0]}, rd);
            chk_word("volt_trim_pin", {10'h000, ~g[5:0]}, {10'h000, voltage_offset_trim});
            tw = 16'($random(seed));
            wr(lvm_pkg::ADDR_ZC_TIMEOUT, tw);
            rdr(lvm_pkg::ADDR_ZC_TIMEOUT, rd);
            chk_word("timeout_rw", tw, rd);
        end
        wr(lvm_pkg::ADDR_ZC_TIMEOUT, 16'h0000);
        wr(lvm_pkg::ADDR_MODE, 16'h0004);
        pulses = 0;
        for (int i = 0; i < 8; i++) begin
            v = {i[0], 19'($random(seed))};
            smp(v);
            chk_bit("zero_cross", ~v[SW-1], zero_cross_out);
        end
        chk_word("temp_pulses", 16'h0001, 16'(pulses));
        rdr(lvm_pkg::ADDR_MODE, rd);
        chk_word("mode_clear", 16'h0000, rd);
        wr(lvm_pkg::ADDR_IRQ_EN, 16'h0001);
        wr(lvm_pkg::ADDR_SAG_LVL, 16'h0038);
        wr(lvm_pkg::ADDR_SAG_CYC, 16'h0002);
        rdr(lvm_pkg::ADDR_STATUS, rd);
        smp(at_level(8'h39, 1'b0));
        for (int i = 0; i < 3; i++) begin
            smp(at_level(8'h38, ~i[0]));
            // The crossing sample closes the half cycle it ends, so two lows land at i == 1
            chk_bit("sag_level", i > 0, sag_n_oe);
        end
        chk_bit("irq_level", 1'b1, irq_n_oe);
        smp(at_level(8'h38, 1'b1));
        chk_bit("sag_hold", 1'b1, sag_n_oe);
        smp(at_level(8'h39, 1'b1));
        chk_bit("sag_release", 1'b0, sag_n_oe);
        rdr(lvm_pkg::ADDR_STATUS, rd);
        chk_word("status_level", 16'h0001, rd);
        chk_bit("irq_cleared", 1'b0, irq_n_oe);
        wr(lvm_pkg::ADDR_SAG_CYC, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            wr(lvm_pkg::ADDR_MODE, {14'h0000, k[0], 1'b0});
            wr(lvm_pkg::ADDR_IRQ_EN, {15'h0000, k[0]});
            wr(lvm_pkg::ADDR_ZC_TIMEOUT, 16'h0003);
            repeat (100) @(negedge mclk);
            smp(at_level(8'h01, k[0]));
            repeat (120) @(negedge mclk);
            chk_bit("sag_reloaded", 1'b0, sag_n_oe);
            repeat (80) @(negedge mclk);
            chk_bit("sag_timeout", ~k[0], sag_n_oe);
            chk_bit("irq_timeout", k[0], irq_n_oe);
            rdr(lvm_pkg::ADDR_STATUS, rd);
            chk_word("flag_timeout", 16'h0003, rd);
        end
        supply_low = 1'b1;
        @(negedge mclk);
        chk_bit("sag_supply", 1'b1, sag_n_oe);
        supply_low = 1'b0;
        rdr(lvm_pkg::ADDR_ZC_TIMEOUT, rd);
        chk_word("timeout_supply", 16'hFFFF, rd);
        close_out();
    end
endmodule // tb_top
